// file: testbench/pidsv_chk.sv
// pidsv_chk: port-level assertions for pidsv_top
// assumes the bind below and the package on the path
`timescale 1ns/1ps
module pidsv_chk
    import pidsv_pkg::*;
(
    // watched ports
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] integLimited,
    input wire logic [15:0] fbDisplay,
    input wire logic [15:0] freqCmd,
    input wire logic        runEnable,
    input wire logic        feedback_loss_indication
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // assertions
    a_setup_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("answer outside access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("answer held too long");
    a_unmapped_err: assert property (pready && paddr > ADDR_OUTVIEW
        |-> pslverr) else $error("unmapped address accepted");
    a_err_zero: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0) else $error("refused read not zero");
    a_fb_ceiling: assert property (fbDisplay <= FB_MAX_LIM)
        else $error("displayed feedback above ceiling");
    a_integ_clamp: assert property ($signed(integLimited) <= 109
        && $signed(integLimited) >= -109) else $error("integ unclamped");
    a_stop_zero: assert property (!runEnable [*3] |->
        freqCmd == 16'h0000) else $error("command while stopped");
    // main scenarios
    c_loss: cover property ($rose(feedback_loss_indication));
    c_stop: cover property ($fell(runEnable));
    c_refuse: cover property (pready && pslverr);
endmodule
bind pidsv_top pidsv_chk chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .integLimited(integLimited),
    .fbDisplay(fbDisplay), .freqCmd(freqCmd), .runEnable(runEnable),
    .feedback_loss_indication(feedback_loss_indication));

// file: testbench/pidsv_plant.sv
// pidsv_plant: feedback transducer and speed loop output
// assumes the bench sets the levels between transfers
`timescale 1ns/1ps
module pidsv_plant (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // bench levels
    input  wire logic [15:0] fbLevel,
    input  wire logic [15:0] demand,
    // drive side
    output logic      [15:0] feedback,
    output logic      [15:0] loopOut
);
    // both settle one cycle after a change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            feedback <= 16'h0000;
            loopOut  <= 16'h0000;
        end else begin
            feedback <= fbLevel;
            loopOut  <= demand;
        end
    end
endmodule

// file: testbench/pidsv_top_tb_top.sv
// pidsv_top_tb_top: directed apb tests of the loop supervisor
// assumes zero-wait apb answers and a 100 MHz clock
`timescale 1ns/1ps
module pidsv_top_tb_top;
    import pidsv_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        pready, pslverr, integClear, runEnable, lossInd, irq;
    logic [15:0] setpoint, feedback, loopOut, integIn, fbLevel, demand;
    logic [15:0] freqCmd, integLimited, derivTerm, fbDisplay;
    int          mismatches, checkCount;
    localparam logic [15:0] FBI [3] = '{16'h00C8, 16'h0014, 16'h0046};
    localparam logic [15:0] FBX [3] = '{16'h0064, 16'h0032, 16'h0046};
    localparam logic [15:0] INI [3] = '{16'h01F4, 16'hFE0C, 16'h000A};
    localparam logic [15:0] INX [3] = '{16'h0028, 16'hFFD8, 16'h000A};
    localparam logic [7:0]  SATA [4] = '{ADDR_ILIM, ADDR_OFFSET,
                                          ADDR_DERIV, ADDR_LAG};
    localparam logic [31:0] SATX [4] = '{32'h6D, 32'h6D, 32'h3E8, 32'h19};
    pidsv_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .setpoint(setpoint), .feedback(feedback),
        .loopOut(loopOut), .integIn(integIn), .freqCmd(freqCmd),
        .integLimited(integLimited), .derivTerm(derivTerm),
        .fbDisplay(fbDisplay), .integClear(integClear),
        .runEnable(runEnable), .feedback_loss_indication(lossInd),
        .irq(irq));
    pidsv_plant plant_u (.clk(clk), .rst_n(rst_n), .fbLevel(fbLevel),
        .demand(demand), .feedback(feedback), .loopOut(loopOut));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer: setup, access until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // clock and timeout
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (6000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    // ==========================================================
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {setpoint, integIn, fbLevel, demand} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        chk(32'(runEnable), 32'h1);
        rd(ADDR_ILIM, 32'h6D);
        rd(ADDR_GAIN, 32'h64);
        rd(ADDR_FBRANGE, 32'h3E7);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(rerr), 32'h1);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ADDR_CTRL, 32'h10 | i);
            rd(ADDR_CTRL, 32'h10 | i);
        end
        $display("test reset and modes done");
        apb(1'b1, ADDR_FBRANGE, 32'h0032_0064);
        apb(1'b1, ADDR_ILIM, 32'h28);
        for (int i = 0; i < 3; i++) begin
            fbLevel <= FBI[i];
            integIn <= INI[i];
            settle();
            chk(32'(fbDisplay), 32'(FBX[i]));
            chk(32'(integLimited), 32'(INX[i]));
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, SATA[i], 32'hFFFF);
            rd(SATA[i], SATX[i]);
        end
        $display("test clamps done");
        apb(1'b1, ADDR_LOSS, 32'h0000_000A);
        setpoint <= 16'h00C8;
        fbLevel  <= 16'h0014;
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, ADDR_CTRL, 32'(m) << 8);
            settle();
            chk(32'(lossInd), 32'(m != 0));
            chk(32'(runEnable), 32'(m != 2));
            chk(32'(irq), 32'(m != 0));
        end
        rd(ADDR_STATUS, 32'hD);
        apb(1'b1, ADDR_IRQMASK, 32'h1);
        settle();
        chk(32'(irq), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        setpoint <= 16'h0014;
        settle();
        chk(32'(lossInd), 32'h0);
        chk(32'(runEnable), 32'h1);
        chk(32'(integClear), 32'h0);
        apb(1'b1, ADDR_IRQSTAT, 32'hF);
        apb(1'b1, ADDR_IRQMASK, 32'h0);
        rd(ADDR_IRQSTAT, 32'h0);
        $display("test loss done");
        apb(1'b1, ADDR_SLEEP, 32'h0000_03E8);
        apb(1'b1, ADDR_WAKE, 32'h0000_07D0);
        demand <= 16'h01F4;
        settle();
        chk(32'(runEnable), 32'h0);
        chk(32'(freqCmd), 32'h0);
        rd(ADDR_STATUS, 32'h4);
        demand <= 16'h0BB8;
        settle();
        chk(32'(runEnable), 32'h1);
        chk(32'(irq), 32'h1);
        rd(ADDR_IRQSTAT, 32'h6);
        $display("test sleep done");
        tally_and_finish();
    end
endmodule

// file: verilog/pidsv_pkg.sv
// pidsv_pkg: constants, register map and types of the pid loop supervisor
// assumes a 100 MHz clock and a 32-bit apb register bus
package pidsv_pkg;
    // ==========
    // clocking and tick
    localparam int CLK_FREQ_HZ    = 100_000_000;
    localparam int TICK_TIME_MS   = 10;        // one control tick = 0.01 s
    localparam int TICK_CYCLES    = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
    localparam int TICKS_PER_TENTH = 10;
    localparam int TICKS_PER_SEC  = 100;
    // ==========
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_DERIV    = 8'h04;
    localparam logic [7:0] ADDR_OFFSET   = 8'h08;
    localparam logic [7:0] ADDR_LAG      = 8'h0C;
    localparam logic [7:0] ADDR_LOSS     = 8'h10;
    localparam logic [7:0] ADDR_ILIM     = 8'h14;
    localparam logic [7:0] ADDR_IRST     = 8'h18;
    localparam logic [7:0] ADDR_SLEEP    = 8'h1C;
    localparam logic [7:0] ADDR_WAKE     = 8'h20;
    localparam logic [7:0] ADDR_FBRANGE  = 8'h24;
    localparam logic [7:0] ADDR_GAIN     = 8'h28;
    localparam logic [7:0] ADDR_STATUS   = 8'h2C;
    localparam logic [7:0] ADDR_IRQSTAT  = 8'h30;
    localparam logic [7:0] ADDR_IRQMASK  = 8'h34;
    localparam logic [7:0] ADDR_FBVIEW   = 8'h38;
    localparam logic [7:0] ADDR_OUTVIEW  = 8'h3C;
    // ==========
    // field limits and reset values
    localparam logic [15:0] DERIV_MAX    = 16'h03E8;  // 10.00 s
    localparam logic [15:0] OFFSET_MAX   = 16'h006D;  // 109 %
    localparam logic [15:0] LAG_MAX      = 16'h0019;  // 2.5 s
    localparam logic [15:0] LEVEL_MAX    = 16'h0064;  // 100
    localparam logic [15:0] DELAY_MAX    = 16'h00FF;  // 25.5 s
    localparam logic [15:0] ILIM_MAX     = 16'h006D;  // 109
    localparam logic [15:0] IRST_MAX     = 16'h001E;  // 30 s
    localparam logic [15:0] MARGIN_MAX   = 16'h0064;  // 100 units
    localparam logic [15:0] FREQ_MAX     = 16'hFDE8;  // 650.00 Hz
    localparam logic [15:0] FB_MAX_LIM   = 16'h03E7;  // 999
    localparam logic [15:0] GAIN_MAX     = 16'h03E8;  // 10.00
    localparam logic [15:0] GAIN_RESET   = 16'h0064;  // 1.00
    localparam logic [15:0] FBMAX_RESET  = 16'h03E7;
    localparam int          GAIN_SHIFT   = 7;         // /128 approximates /100
    localparam int          NUM_EVENTS   = 4;
    // event bit positions
    localparam int EV_LOSS  = 0;
    localparam int EV_SLEEP = 1;
    localparam int EV_WAKE  = 2;
    localparam int EV_IRST  = 3;
    // ==========
    // loop operation modes
    typedef enum logic [2:0] {
        PIDSV_OFF      = 3'h0,
        PIDSV_DEV_D    = 3'h1,
        PIDSV_FB_D     = 3'h2,
        PIDSV_DEV_D_RV = 3'h3,
        PIDSV_FB_D_RV  = 3'h4
    } pidsv_op_t;
    // run state, gray along run -> sleep / reset-stop -> run
    typedef enum logic [1:0] {
        PIDSV_RUN   = 2'b00,
        PIDSV_SLEEP = 2'b01,
        PIDSV_IHOLD = 2'b10,
        PIDSV_LOST  = 2'b11
    } pidsv_state_t;
endpackage

// file: verilog/pidsv_timer.sv
// pidsv_timer: counts control ticks while a condition holds
// assumes a one-cycle tick enable and a preset in tick units
`timescale 1ns/1ps
module pidsv_timer #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // control
    input  wire logic         tick,
    input  wire logic         cond,
    input  wire logic [W-1:0] limit,
    // result
    output logic              done
);
    logic [W-1:0] cnt_q;

    // ==========
    // count ticks while cond, restart when it drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!cond) begin
            cnt_q <= '0;
        end else if (tick && cnt_q < limit) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    // done once held for the whole limit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= cond && (cnt_q >= limit);
        end
    end
endmodule

// file: verilog/pidsv_top.sv
// pidsv_top: supervisory and shaping logic around the pid speed loop
// assumes setpoint/feedback as signed 16-bit words synchronous to clk
// and an apb master for configuration
// Summary of operation
// R01: derivative unit time programmable 0..10.00 s in hundredths.
// R02: polarity 0 adds offset positively, 1 applies it negatively.
// R03: loop output shifted by offset 0..109 percent with chosen polarity.
// R04: output passes a first-order lag, time constant 0..2.5 s.
// R05: mode 0 no loss check; mode 1 detect, keep running, flag.
// R06: mode 2 stops the motor on loss and flags it.
// R07: loss when setpoint minus feedback exceeds level 0..100.
// R08: loss condition must persist delay 0..25.5 s before declared.
// R09: integrator clamped at limit 0..109.
// R10: reset time zero never clears the integrator.
// R11: reset time 1..30 s clears integrator after match, then stops.
// R12: after reset stop, resume once feedback leaves setpoint.
// R13: restart margin 0..100 units of 1/8192.
// R14: output below sleep level longer than delay: decelerate, sleep.
// R15: asleep, output above wake level for delay: restart, wake.
// R16: displayed feedback clamped between min and max 0..999.
// R17: deviation is setpoint minus feedback times gain 0..10.00.
// R18: derivative on deviation or feedback; reverse modes invert.
// R19: all delays derive from one fixed 10 ms control tick.
`timescale 1ns/1ps
module pidsv_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // loop signals
    input  wire logic [15:0] setpoint,
    input  wire logic [15:0] feedback,
    input  wire logic [15:0] loopOut,
    input  wire logic [15:0] integIn,
    // results
    output logic      [15:0] freqCmd,
    output logic      [15:0] integLimited,
    output logic      [15:0] derivTerm,
    output logic      [15:0] fbDisplay,
    output logic             integClear,
    output logic             runEnable,
    output logic             feedback_loss_indication,
    output logic             irq
);
    import pidsv_pkg::*;
    // ==========
    // configuration registers
    logic [2:0]  opMode_q;
    logic        offNeg_q;
    logic [1:0]  lossMode_q;
    logic [15:0] deriv_q, offset_q, lag_q, lossLvl_q, lossDly_q;
    logic [15:0] ilim_q, irst_q, margin_q;
    logic [15:0] sleepLvl_q, sleepDly_q, wakeLvl_q, wakeDly_q;
    logic [15:0] fbMax_q, fbMin_q, gain_q;
    logic [NUM_EVENTS-1:0] irqStat_q, irqMask_q, evt;
    pidsv_state_t state_q;
    logic wrEn;
    assign wrEn = psel && penable && pwrite;
    // saturate a written value at its field maximum
    function automatic logic [15:0] sat(input logic [31:0] v,
                                        input logic [15:0] m);
        sat = (v[31:16] != 16'h0000 || v[15:0] > m) ? m : v[15:0];
    endfunction
    // known register map test
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= ADDR_OUTVIEW) && (a[1:0] == 2'b00);
    endfunction
    // register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opMode_q   <= 3'h0;
            offNeg_q   <= 1'b0;
            lossMode_q <= 2'h0;
            deriv_q    <= 16'h0000;
            offset_q   <= 16'h0000;
            lag_q      <= 16'h0000;
            lossLvl_q  <= 16'h0000;
            lossDly_q  <= 16'h0000;
            ilim_q     <= ILIM_MAX;
            irst_q     <= 16'h0000;
            margin_q   <= 16'h0000;
            sleepLvl_q <= 16'h0000;
            sleepDly_q <= 16'h0000;
            wakeLvl_q  <= 16'h0000;
            wakeDly_q  <= 16'h0000;
            fbMax_q    <= FBMAX_RESET;
            fbMin_q    <= 16'h0000;
            gain_q     <= GAIN_RESET;
            irqMask_q  <= '0;
        end else if (wrEn) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    opMode_q   <= (pwdata[2:0] > 3'h4) ? 3'h0 : pwdata[2:0];
                    offNeg_q   <= pwdata[4];              // R02
                    lossMode_q <= (pwdata[9:8] == 2'h3) ? 2'h0 : pwdata[9:8];
                end
                ADDR_DERIV:   deriv_q    <= sat(pwdata, DERIV_MAX);  // R01
                ADDR_OFFSET:  offset_q   <= sat(pwdata, OFFSET_MAX); // R03
                ADDR_LAG:     lag_q      <= sat(pwdata, LAG_MAX);    // R04
                ADDR_LOSS: begin
                    lossLvl_q <= sat({16'h0000, pwdata[15:0]}, LEVEL_MAX);
                    lossDly_q <= sat({16'h0000, pwdata[31:16]}, DELAY_MAX);
                end
                ADDR_ILIM:    ilim_q     <= sat(pwdata, ILIM_MAX);   // R09
                ADDR_IRST: begin
                    irst_q   <= sat({16'h0000, pwdata[15:0]}, IRST_MAX);
                    margin_q <= sat({16'h0000, pwdata[31:16]}, MARGIN_MAX);
                end
                ADDR_SLEEP: begin
                    sleepLvl_q <= sat({16'h0000, pwdata[15:0]}, FREQ_MAX);
                    sleepDly_q <= sat({16'h0000, pwdata[31:16]}, DELAY_MAX);
                end
                ADDR_WAKE: begin
                    wakeLvl_q <= sat({16'h0000, pwdata[15:0]}, FREQ_MAX);
                    wakeDly_q <= sat({16'h0000, pwdata[31:16]}, DELAY_MAX);
                end
                ADDR_FBRANGE: begin
                    fbMax_q <= sat({16'h0000, pwdata[15:0]}, FB_MAX_LIM);
                    fbMin_q <= sat({16'h0000, pwdata[31:16]}, FB_MAX_LIM);
                end
                ADDR_GAIN:    gain_q     <= sat(pwdata, GAIN_MAX);   // R17
                ADDR_IRQMASK: irqMask_q  <= pwdata[NUM_EVENTS-1:0];
                default: ;
            endcase
        end
    end
    // ==========
    // control tick divider
    logic [23:0] divCnt_q;
    logic        tick_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= '0;
            tick_q   <= 1'b0;
        end else if (divCnt_q == 24'(TICK_CYCLES - 1)) begin
            divCnt_q <= '0;                                   // R19
            tick_q   <= 1'b1;
        end else begin
            divCnt_q <= divCnt_q + 24'h000001;
            tick_q   <= 1'b0;
        end
    end
    // tenths-of-second delays scaled to ticks
    function automatic logic [15:0] tenths(input logic [15:0] t);
        tenths = 16'(t * 16'(TICKS_PER_TENTH));
    endfunction
    // ==========
    // deviation with calibration gain
    logic signed [31:0] fbScaled;
    logic signed [16:0] deviation, lossErr;
    assign fbScaled  = ($signed(feedback) * $signed({1'b0, gain_q}))
                       >>> GAIN_SHIFT;                        // R17
    assign deviation = 17'($signed(setpoint) - fbScaled);
    assign lossErr   = $signed(setpoint) - $signed(feedback); // R07
    // derivative: sample every derivative unit time
    logic [15:0] dCnt_q;
    logic signed [16:0] dPrev_q, dSrc, dDiff;
    assign dSrc  = (opMode_q == PIDSV_FB_D || opMode_q == PIDSV_FB_D_RV) ?
                   -$signed({feedback[15], feedback}) : deviation; // R18
    assign dDiff = dSrc - dPrev_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dCnt_q    <= '0;
            dPrev_q   <= '0;
            derivTerm <= '0;
        end else if (opMode_q == PIDSV_OFF) begin
            derivTerm <= '0;
        end else if (tick_q) begin
            if (dCnt_q >= deriv_q) begin                       // R01
                dCnt_q  <= '0;
                dPrev_q <= dSrc;
                derivTerm <= (opMode_q == PIDSV_DEV_D_RV ||
                              opMode_q == PIDSV_FB_D_RV) ?
                             16'(-dDiff) : 16'(dDiff);         // R18
            end else begin
                dCnt_q <= dCnt_q + 16'h0001;
            end
        end
    end
    // integrator clamp
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            integLimited <= '0;
        end else if ($signed(integIn) > $signed(ilim_q)) begin
            integLimited <= ilim_q;                            // R09
        end else if ($signed(integIn) < -$signed(ilim_q)) begin
            integLimited <= 16'(-$signed(ilim_q));
        end else begin
            integLimited <= integIn;
        end
    end
    // ==========
    // offset and lag filter
    logic signed [17:0] shifted;
    logic signed [31:0] lagAcc_q;
    assign shifted = offNeg_q ?
        18'($signed(loopOut) - $signed({1'b0, offset_q})) :   // R02
        18'($signed(loopOut) + $signed({1'b0, offset_q}));    // R03
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lagAcc_q <= '0;
        end else if (lag_q == 16'h0000) begin
            lagAcc_q <= 32'(shifted) <<< 8;
        end else if (tick_q) begin
            // one step per tick, weight 1/(tenths*10)
            lagAcc_q <= lagAcc_q + (((32'(shifted) <<< 8) - lagAcc_q) /
                        $signed({16'h0000, tenths(lag_q)}));   // R04
        end
    end
    // output command forced to zero while not running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freqCmd <= '0;
        end else begin
            freqCmd <= runEnable ? 16'(lagAcc_q >>> 8) : 16'h0000;
        end
    end
    // ==========
    // timers
    logic lossDone, matchDone, sleepDone, wakeDone;
    logic lossCond, matchCond, sleepCond, wakeCond;
    logic [16:0] absDev;
    assign absDev    = lossErr[16] ? 17'(-lossErr) : lossErr;
    assign lossCond  = lossMode_q != 2'h0 &&
                       lossErr > $signed({1'b0, lossLvl_q});   // R05 R07
    assign matchCond = irst_q != 16'h0000 && state_q == PIDSV_RUN &&
                       absDev == 17'h00000;                    // R10
    assign sleepCond = state_q == PIDSV_RUN && loopOut < sleepLvl_q;
    assign wakeCond  = state_q == PIDSV_SLEEP && loopOut > wakeLvl_q;
    pidsv_timer #(.W(16)) uLoss (
        .clk(clk), .rst_n(rst_n), .tick(tick_q), .cond(lossCond),
        .limit(tenths(lossDly_q)), .done(lossDone));           // R08
    pidsv_timer #(.W(16)) uMatch (
        .clk(clk), .rst_n(rst_n), .tick(tick_q), .cond(matchCond),
        .limit(16'(irst_q * 16'(TICKS_PER_SEC))), .done(matchDone)); // R11
    pidsv_timer #(.W(16)) uSleep (
        .clk(clk), .rst_n(rst_n), .tick(tick_q), .cond(sleepCond),
        .limit(tenths(sleepDly_q)), .done(sleepDone));         // R14
    pidsv_timer #(.W(16)) uWake (
        .clk(clk), .rst_n(rst_n), .tick(tick_q), .cond(wakeCond),
        .limit(tenths(wakeDly_q)), .done(wakeDone));           // R15
    // ==========
    // run state machine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PIDSV_RUN;
        end else begin
            unique case (state_q)
                PIDSV_RUN: begin
                    if (lossDone && lossMode_q == 2'h2)
                        state_q <= PIDSV_LOST;                 // R06
                    else if (matchDone)
                        state_q <= PIDSV_IHOLD;                // R11
                    else if (sleepDone)
                        state_q <= PIDSV_SLEEP;                // R14
                end
                PIDSV_IHOLD: begin
                    if (absDev > {1'b0, margin_q})
                        state_q <= PIDSV_RUN;                  // R12 R13
                end
                PIDSV_SLEEP: begin
                    if (wakeDone)
                        state_q <= PIDSV_RUN;                  // R15
                end
                PIDSV_LOST: begin
                    if (lossMode_q != 2'h2)
                        state_q <= PIDSV_RUN;
                end
            endcase
        end
    end
    // run, clear and loss outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            runEnable  <= 1'b1;
            integClear <= 1'b0;
            feedback_loss_indication <= 1'b0;
        end else begin
            runEnable  <= (state_q == PIDSV_RUN);
            integClear <= matchDone && state_q == PIDSV_RUN;   // R11
            feedback_loss_indication <= lossDone;              // R05 R06
        end
    end
    // displayed feedback clamp
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fbDisplay <= '0;
        end else if ($signed(feedback) > $signed(fbMax_q)) begin
            fbDisplay <= fbMax_q;                              // R16
        end else if ($signed(feedback) < $signed(fbMin_q)) begin
            fbDisplay <= fbMin_q;
        end else begin
            fbDisplay <= feedback;
        end
    end
    // ==========
    // interrupts: sticky, write one to clear, set wins, mask 1 blocks
    logic lossSeen_q, sleepSeen_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lossSeen_q  <= 1'b0;
            sleepSeen_q <= 1'b0;
        end else begin
            lossSeen_q  <= lossDone;
            sleepSeen_q <= state_q == PIDSV_SLEEP;
        end
    end
    assign evt[EV_LOSS]  = lossDone && !lossSeen_q;
    assign evt[EV_SLEEP] = state_q == PIDSV_SLEEP && !sleepSeen_q;
    assign evt[EV_WAKE]  = state_q != PIDSV_SLEEP && sleepSeen_q;
    assign evt[EV_IRST]  = matchDone && state_q == PIDSV_RUN;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_q <= '0;
            irq       <= 1'b0;
        end else begin
            irqStat_q <= (irqStat_q &
                ~((wrEn && paddr == ADDR_IRQSTAT) ?
                  pwdata[NUM_EVENTS-1:0] : '0)) | evt;
            irq <= |(irqStat_q & ~irqMask_q);
        end
    end
    // ==========
    // apb read and answer, zero wait states
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            prdata  <= '0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    ADDR_CTRL:    prdata <= {22'h0, lossMode_q, 3'h0,
                                             offNeg_q, 1'b0, opMode_q};
                    ADDR_DERIV:   prdata <= {16'h0, deriv_q};
                    ADDR_OFFSET:  prdata <= {16'h0, offset_q};
                    ADDR_LAG:     prdata <= {16'h0, lag_q};
                    ADDR_LOSS:    prdata <= {lossDly_q, lossLvl_q};
                    ADDR_ILIM:    prdata <= {16'h0, ilim_q};
                    ADDR_IRST:    prdata <= {margin_q, irst_q};
                    ADDR_SLEEP:   prdata <= {sleepDly_q, sleepLvl_q};
                    ADDR_WAKE:    prdata <= {wakeDly_q, wakeLvl_q};
                    ADDR_FBRANGE: prdata <= {fbMin_q, fbMax_q};
                    ADDR_GAIN:    prdata <= {16'h0, gain_q};
                    ADDR_STATUS:  prdata <= {28'h0, state_q, runEnable,
                                             feedback_loss_indication};
                    ADDR_IRQSTAT: prdata <= {28'h0, irqStat_q};
                    ADDR_IRQMASK: prdata <= {28'h0, irqMask_q};
                    ADDR_FBVIEW:  prdata <= {16'h0, fbDisplay};
                    ADDR_OUTVIEW: prdata <= {16'h0, freqCmd};
                    default:      prdata <= '0;
                endcase
            end
        end
    end
endmodule
